/* rtl/vis_irq_ctrl.v */
// Contract
// [R1] each of ten sources has a fixed vector 003H..01EH
// [R2] priority one is external pin, ten is timer C, vector order
// [R3] software reads port 5 before enabling the port change interrupt
// [R4] port 5 change wakes from sleep if enabled before sleep
// [R5] after port wake: continue if global disabled, else vector 006H
// [R6] external input filter drops pulses under 8 clocks
// [R7] low-frequency crystal mode bypasses the filter
// [R8] external edge chosen by edge-select bit of timer config
// [R9] global enable set by enable op, cleared by disable op
// [R10] service routine clears its flag before returning
// [R11] primary flags set regardless of global enable, port change excepted
// [R12] primary flag read returns flags AND mask
// [R13] return op ends routine and sets global enable
// [R14] hardware saves working, status, pointer before routine; restores after
// [R15] nested acceptance overwrites the shadow copies
// [R16] reset from power-on, reset pin low, or enabled watchdog time-out
// [R17] reset pin clears wake flag; keeps or sets time-out/power-down per mode
// [R18] watchdog reset clears wake and time-out; power-down per mode
// [R19] pin change wake sets wake flag, time-out, clears power-down
// [R20] power-on, watchdog clear and sleep ops set time-out/power-down; the sleep op here clears power-down
// [R21] flag registers clear on resets, kept on pin change wake
// [R22] highest-priority pending enabled source is vectored first
//
// Implementation choice: the plain strobed port.
`timescale 1ns/1ps
`include "vis_map.vh"
module vis_irq_ctrl #(
    parameter FILT_CLKS = `VIS_FILT_CLKS
) (
    input wire ref_clk,                 // system clock
    input wire sys_rst,                 // power-on reset, active high
    input wire rst_pin_n,               // reset pin, asynchronous
    input wire wdt_timeout,             // watchdog time-out pulse
    input wire wdt_enable,              // watchdog enabled

    input wire low_freq_crystal_mode,   // filter bypass select
    input wire ext_pin,                 // external interrupt pin, asynchronous
    input wire [7:0] port5_pins,        // port 5 inputs, asynchronous

    input wire main_tmr_ev,             // main timer overflow pulse
    input wire tmr_a_ev,                // timer a overflow pulse
    input wire tmr_b_ev,                // timer b overflow pulse
    input wire tmr_c_ev,                // timer c overflow pulse
    input wire hi_pulse_ev,             // high pulse underflow pulse
    input wire lo_pulse_ev,             // low pulse underflow pulse
    input wire conv_ev,                 // conversion done pulse
    input wire cmp_ev,                  // comparator change pulse
    input wire [11:0] conv_result,      // conversion result

    input wire global_irq_enable_op,    // enable op executed
    input wire global_irq_disable_op,   // disable op executed
    input wire irq_return_op,           // return op executed
    input wire sleep_op,                // sleep op executed
    input wire watchdog_clear_op,       // watchdog clear op executed

    input wire irq_ack,                 // core accepts the vector
    input wire [7:0] working_register,  // live working register
    input wire [7:0] status_word,       // live status word
    input wire [7:0] indirect_pointer,  // live indirect pointer

    input wire [5:0] reg_addr,          // register address
    input wire [7:0] reg_wdata,         // write data
    input wire reg_wr,                  // write strobe
    input wire reg_rd,                  // read strobe

    output reg [7:0] reg_rdata,         // read data, cycle after strobe
    output wire irq_req,                // vector request to core
    output reg [9:0] irq_vector,        // vector address
    output wire wake,                   // wake request to core
    output wire wake_resume_inline,     // wake without branch
    output wire chip_reset,             // combined reset request

    output reg [7:0] shadow_work,       // saved working register
    output reg [7:0] shadow_status,     // saved status word
    output reg [7:0] shadow_ptr,        // saved indirect pointer
    output reg restore_ctx,             // pulse: restore saved context

    output reg sleeping,                // device in sleep
    output reg flag_time_out,           // time-out flag
    output reg flag_power_down,         // power-down flag
    output reg flag_pin_wake            // pin change wake flag
);
    reg [7:0] pri_r;
    reg [7:0] sec_r;
    reg [7:0] mask_pri_r;
    reg [7:0] mask_sec_r;
    reg [7:0] tconf_r;
    reg [7:0] ram_r [0:47];
    reg [11:0] res_r;
    reg gie_r;

    reg ext_s1_r, ext_s2_r, rst_s1_r, rst_s2_r;
    reg [7:0] p5_s1_r, p5_s2_r, p5_ref_r;
    reg [3:0] filt_cnt_r;
    reg ext_filt_r, ext_prev_r;
    reg rst_prev_r;

    reg [7:0] pri_set;
    reg [7:0] sec_set;

    wire ext_level;
    wire ext_edge;
    wire port_chg;
    wire rst_pin_ev;
    wire wdt_rst_ev;
    wire [9:0] pend;

    // two flip-flop synchronisers for all pins
    always @(posedge ref_clk) begin
        ext_s1_r <= ext_pin;
        ext_s2_r <= ext_s1_r;
        rst_s1_r <= rst_pin_n;
        rst_s2_r <= rst_s1_r;
        p5_s1_r <= port5_pins;
        p5_s2_r <= p5_s1_r;
    end

    // glitch filter: level must hold FILT_CLKS clocks before it is believed
    // every accepted edge arrives FILT_CLKS clocks late
    always @(posedge ref_clk) begin
        if (sys_rst) begin
            filt_cnt_r <= 4'h0;
            ext_filt_r <= 1'b0;
        end else if (ext_s2_r == ext_filt_r) begin
            filt_cnt_r <= 4'h0;
        end else if (filt_cnt_r == FILT_CLKS[3:0] - 4'h1) begin
            filt_cnt_r <= 4'h0;
            ext_filt_r <= ext_s2_r; // [R6]
        end else begin
            filt_cnt_r <= filt_cnt_r + 4'h1;
        end
    end

    assign ext_level = low_freq_crystal_mode ? ext_s2_r : ext_filt_r; // [R7]
    // edge select: 1 picks rising, 0 picks falling
    assign ext_edge = tconf_r[`VIS_TC_EDGE] ? (ext_level & ~ext_prev_r) : (~ext_level & ext_prev_r); // [R8]
    // change against the reference latched on a port 5 read
    assign port_chg = |(p5_s2_r ^ p5_ref_r);
    // flags clear once, on the falling edge of the synced pin
    assign rst_pin_ev = rst_prev_r & ~rst_s2_r; // [R16]
    assign wdt_rst_ev = wdt_timeout & wdt_enable; // [R16]
    assign chip_reset = sys_rst | ~rst_s2_r | wdt_rst_ev; // [R16]

    always @(posedge ref_clk) begin
        if (sys_rst) begin
            ext_prev_r <= 1'b0;
            rst_prev_r <= 1'b1;
            p5_ref_r <= 8'h00;
        end else begin
            ext_prev_r <= ext_level;
            rst_prev_r <= rst_s2_r;
            // the reference is only refreshed by a software read of port 5
            if (reg_rd && reg_addr == `VIS_OFF_PORT5)
                p5_ref_r <= p5_s2_r; // [R3]
        end
    end

    // hardware set terms; port change needs its mask, others are free-running
    always @* begin
        pri_set = 8'h00;
        pri_set[`VIS_PF_MAIN_TMR] = main_tmr_ev; // [R11]
        pri_set[`VIS_PF_PORT_CHG] = port_chg & mask_pri_r[`VIS_PF_PORT_CHG];
        pri_set[`VIS_PF_EXT] = ext_edge;
        pri_set[`VIS_PF_TMR_A] = tmr_a_ev;
        pri_set[`VIS_PF_TMR_B] = tmr_b_ev;
        pri_set[`VIS_PF_TMR_C] = tmr_c_ev;
        pri_set[`VIS_PF_HI_PULSE] = hi_pulse_ev;
        pri_set[`VIS_PF_LO_PULSE] = lo_pulse_ev;
        sec_set = 8'h00;
        sec_set[`VIS_SF_CONV] = conv_ev;
        sec_set[`VIS_SF_CMP] = cmp_ev;
    end

    // flag registers: set wins over a software write in the same cycle
    always @(posedge ref_clk) begin
        if (sys_rst || rst_pin_ev || wdt_rst_ev) begin
            pri_r <= 8'h00; // [R21]
            sec_r <= 8'h00; // [R21]
        end else begin
            if (reg_wr && reg_addr == `VIS_OFF_PRI_FLAGS)
                pri_r <= reg_wdata | pri_set; // [R10]
            else
                pri_r <= pri_r | pri_set; // [R11]
            if (reg_wr && reg_addr == `VIS_OFF_SEC_FLAGS)
                sec_r <= (reg_wdata & `VIS_SEC_WMASK) | sec_set;
            else
                sec_r <= sec_r | sec_set;
        end
    end

    // masks, timer configuration, result latch
    always @(posedge ref_clk) begin
        if (sys_rst || rst_pin_ev || wdt_rst_ev) begin
            mask_pri_r <= 8'h00;
            mask_sec_r <= 8'h00;
            tconf_r <= `VIS_TCONF_RST;
        end else begin
            if (reg_wr && reg_addr == `VIS_OFF_MASK_PRI)
                mask_pri_r <= reg_wdata;
            if (reg_wr && reg_addr == `VIS_OFF_MASK_SEC)
                mask_sec_r <= reg_wdata;
            if (reg_wr && reg_addr == `VIS_OFF_TCONF)
                tconf_r <= reg_wdata;
        end
        // the result survives pin and watchdog resets
        if (sys_rst)
            res_r <= 12'h000;
        else if (conv_ev)
            res_r <= conv_result;
    end

    // general purpose storage survives all but power-on
    genvar gi;
    generate
        for (gi = 0; gi < 48; gi = gi + 1) begin : g_ram
            // index cut to the port width on purpose; 48 words end at 0x3f
            localparam [31:0] WORD_IDX = gi;
            localparam [5:0] WORD_OFF = `VIS_OFF_RAM_LO + WORD_IDX[5:0];
            always @(posedge ref_clk) begin
                if (sys_rst)
                    ram_r[gi] <= 8'h00;
                else if (reg_wr && reg_addr == WORD_OFF)
                    ram_r[gi] <= reg_wdata; // [R21]
            end
        end
    endgenerate

    // read port, one cycle latency; unmapped addresses read zero
    always @(posedge ref_clk) begin
        if (sys_rst) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            if (reg_addr >= `VIS_OFF_RAM_LO)
                reg_rdata <= ram_r[reg_addr - `VIS_OFF_RAM_LO];
            else begin
                case (reg_addr)
                    `VIS_OFF_PRI_FLAGS: reg_rdata <= pri_r & mask_pri_r; // [R12]
                    `VIS_OFF_SEC_FLAGS: reg_rdata <= sec_r;
                    `VIS_OFF_RES_HI: reg_rdata <= {4'h0, res_r[11:8]};
                    `VIS_OFF_RES_LO: reg_rdata <= res_r[7:0];
                    `VIS_OFF_MASK_PRI: reg_rdata <= mask_pri_r;
                    `VIS_OFF_MASK_SEC: reg_rdata <= mask_sec_r;
                    `VIS_OFF_TCONF: reg_rdata <= tconf_r;
                    `VIS_OFF_STATUS: reg_rdata <= {4'h0, gie_r, flag_pin_wake, flag_time_out, flag_power_down};
                    default: reg_rdata <= 8'h00;
                endcase
            end
        end else begin
            reg_rdata <= 8'h00;
        end
    end

    // pending enabled sources in priority order, bit 0 highest
    assign pend = {pri_r[`VIS_PF_TMR_C] & mask_pri_r[`VIS_PF_TMR_C],
                   pri_r[`VIS_PF_TMR_B] & mask_pri_r[`VIS_PF_TMR_B],
                   pri_r[`VIS_PF_TMR_A] & mask_pri_r[`VIS_PF_TMR_A],
                   pri_r[`VIS_PF_LO_PULSE] & mask_pri_r[`VIS_PF_LO_PULSE],
                   pri_r[`VIS_PF_HI_PULSE] & mask_pri_r[`VIS_PF_HI_PULSE],
                   sec_r[`VIS_SF_CMP] & mask_sec_r[`VIS_SF_CMP],
                   sec_r[`VIS_SF_CONV] & mask_sec_r[`VIS_SF_CONV],
                   pri_r[`VIS_PF_MAIN_TMR] & mask_pri_r[`VIS_PF_MAIN_TMR],
                   pri_r[`VIS_PF_PORT_CHG] & mask_pri_r[`VIS_PF_PORT_CHG],
                   pri_r[`VIS_PF_EXT] & mask_pri_r[`VIS_PF_EXT]};

    // fixed priority encoder; flags stay set, only the winner is vectored
    always @* begin
        if (pend[0]) irq_vector = `VIS_VEC_EXT; // [R1] [R2] [R22]
        else if (pend[1]) irq_vector = `VIS_VEC_PORT;
        else if (pend[2]) irq_vector = `VIS_VEC_MAIN_TMR;
        else if (pend[3]) irq_vector = `VIS_VEC_CONV;
        else if (pend[4]) irq_vector = `VIS_VEC_CMP;
        else if (pend[5]) irq_vector = `VIS_VEC_HI_PULSE;
        else if (pend[6]) irq_vector = `VIS_VEC_LO_PULSE;
        else if (pend[7]) irq_vector = `VIS_VEC_TMR_A;
        else if (pend[8]) irq_vector = `VIS_VEC_TMR_B;
        else if (pend[9]) irq_vector = `VIS_VEC_TMR_C;
        else irq_vector = 10'h000;
    end

    // no request while asleep: the core must wake first
    assign irq_req = gie_r & (|pend) & ~sleeping;
    // port change wakes whenever its enable was set before sleep
    assign wake = sleeping & port_chg & mask_pri_r[`VIS_PF_PORT_CHG]; // [R4]
    assign wake_resume_inline = wake & ~gie_r; // [R5]

    // global enable and context shadow
    // ack beats an enable op in one cycle, so service starts masked
    always @(posedge ref_clk) begin
        if (sys_rst || rst_pin_ev || wdt_rst_ev) begin
            gie_r <= 1'b0;
            restore_ctx <= 1'b0;
            shadow_work <= 8'h00;
            shadow_status <= 8'h00;
            shadow_ptr <= 8'h00;
        end else begin
            restore_ctx <= irq_return_op; // [R14]
            if (irq_req && irq_ack) begin
                gie_r <= 1'b0;
                shadow_work <= working_register; // [R14] [R15]
                shadow_status <= status_word;
                shadow_ptr <= indirect_pointer;
            end else if (global_irq_enable_op || irq_return_op)
                gie_r <= 1'b1; // [R9] [R13]
            else if (global_irq_disable_op)
                gie_r <= 1'b0; // [R9]
        end
    end

    // sleep state and wake-cause flags; port wake keeps flag registers [R21]
    always @(posedge ref_clk) begin
        if (sys_rst) begin
            sleeping <= 1'b0;
            flag_time_out <= 1'b1; // [R20]
            flag_power_down <= 1'b1;
            flag_pin_wake <= 1'b0;
        end else if (rst_pin_ev) begin
            sleeping <= 1'b0;
            flag_pin_wake <= 1'b0; // [R17]
            if (sleeping) begin
                flag_time_out <= 1'b1;
                flag_power_down <= 1'b0;
            end
        end else if (wdt_rst_ev) begin
            sleeping <= 1'b0;
            flag_pin_wake <= 1'b0; // [R18]
            flag_time_out <= 1'b0;
            flag_power_down <= ~sleeping;
        end else if (wake) begin
            sleeping <= 1'b0;
            flag_pin_wake <= 1'b1; // [R19]
            flag_time_out <= 1'b1;
            flag_power_down <= 1'b0;
        end else if (sleep_op) begin
            sleeping <= 1'b1;
            flag_time_out <= 1'b1; // [R20]
            flag_power_down <= 1'b0;
        end else if (watchdog_clear_op) begin
            flag_time_out <= 1'b1; // [R20]
            flag_power_down <= 1'b1;
        end
    end
endmodule // vis_irq_ctrl

/* rtl/vis_map.vh */
`ifndef VIS_MAP_VH
`define VIS_MAP_VH
// register offsets (byte-wide registers on the plain port)
`define VIS_ADDR_W 6
`define VIS_OFF_RES_HI 6'h0c
`define VIS_OFF_RES_LO 6'h0d
`define VIS_OFF_SEC_FLAGS 6'h0e
`define VIS_OFF_PRI_FLAGS 6'h0f
`define VIS_OFF_RAM_LO 6'h10
`define VIS_OFF_RAM_HI 6'h3f
`define VIS_OFF_MASK_PRI 6'h01
`define VIS_OFF_MASK_SEC 6'h02
`define VIS_OFF_TCONF 6'h03
`define VIS_OFF_STATUS 6'h04
`define VIS_OFF_PORT5 6'h05
// primary flag bit positions
`define VIS_PF_MAIN_TMR 0
`define VIS_PF_PORT_CHG 1
`define VIS_PF_EXT 2
`define VIS_PF_TMR_A 3
`define VIS_PF_TMR_B 4
`define VIS_PF_TMR_C 5
`define VIS_PF_HI_PULSE 6
`define VIS_PF_LO_PULSE 7
// secondary flag bit positions
`define VIS_SF_PC_WAKE_EN 1
`define VIS_SF_CMP_WAKE_EN 2
`define VIS_SF_CONV_WAKE_EN 3
`define VIS_SF_CMP 4
`define VIS_SF_CONV 5
`define VIS_SEC_WMASK 8'h3e
// timer configuration edge-select bit and reset value
`define VIS_TC_EDGE 7
`define VIS_TCONF_RST 8'hb0
// vectors
`define VIS_VEC_EXT 10'h003
`define VIS_VEC_PORT 10'h006
`define VIS_VEC_MAIN_TMR 10'h009
`define VIS_VEC_CONV 10'h00c
`define VIS_VEC_CMP 10'h00f
`define VIS_VEC_HI_PULSE 10'h012
`define VIS_VEC_LO_PULSE 10'h015
`define VIS_VEC_TMR_A 10'h018
`define VIS_VEC_TMR_B 10'h01b
`define VIS_VEC_TMR_C 10'h01e
// noise filter length in system clocks
`define VIS_FILT_CLKS 8
`endif

/* test/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
    reg ref_clk = 1'b0;
    reg sys_rst = 1'b1;
    reg rst_pin_n = 1'b1;
    reg wdt_enable = 1'b0;
    reg low_freq_crystal_mode = 1'b0;
    reg ext_pin = 1'b0;
    reg slow = 1'b0;
    reg pd = 1'b0;
    reg [7:0] port5 = 8'h00;
    reg [7:0] ev = 8'h00; // {cmp,conv,lo,hi,c,b,a,main}
    reg [5:0] op = 6'h00; // {wdt,wdc,sleep,ret,dis,en}
    reg [5:0] reg_addr = 6'h00;
    reg [7:0] reg_wdata = 8'h00;
    reg reg_wr = 1'b0;
    reg reg_rd = 1'b0;
    reg [7:0] last = 8'h00;
    wire [7:0] reg_rdata, work, stat, ptr, sh_w, sh_s, sh_p;
    wire [9:0] irq_vector;
    wire irq_req, irq_ack, wake, inl, rst_c, rc, sleeping, t_o, p_d, p_w;
    integer n_errors = 0;
    integer checked = 0;
    integer i;
    integer k;
    // service order by priority and the flag write that retires each
    localparam [79:0] VQ = {10'h009, 10'h00c, 10'h00f, 10'h012, 10'h015, 10'h018, 10'h01b, 10'h01e};
    localparam [47:0] CA = {6'h0f, 6'h0e, 6'h0e, 6'h0f, 6'h0f, 6'h0f, 6'h0f, 6'h0f};
    localparam [63:0] CD = {8'hf8, 8'h10, 8'h00, 8'hb8, 8'h38, 8'h30, 8'h20, 8'h00};
    always #2 ref_clk = ~ref_clk;
    vis_irq_ctrl dut (.ref_clk, .sys_rst, .rst_pin_n, .wdt_timeout(op[5]), .wdt_enable,
        .low_freq_crystal_mode, .ext_pin, .port5_pins(port5), .main_tmr_ev(ev[0]), .tmr_a_ev(ev[1]),
        .tmr_b_ev(ev[2]), .tmr_c_ev(ev[3]), .hi_pulse_ev(ev[4]), .lo_pulse_ev(ev[5]), .conv_ev(ev[6]),
        .cmp_ev(ev[7]), .conv_result(12'h5a3), .global_irq_enable_op(op[0]), .global_irq_disable_op(op[1]),
        .irq_return_op(op[2]), .sleep_op(op[3]), .watchdog_clear_op(op[4]), .irq_ack, .working_register(work),
        .status_word(stat), .indirect_pointer(ptr), .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
        .irq_req, .irq_vector, .wake, .wake_resume_inline(inl), .chip_reset(rst_c), .shadow_work(sh_w),
        .shadow_status(sh_s), .shadow_ptr(sh_p), .restore_ctx(rc), .sleeping, .flag_time_out(t_o),
        .flag_power_down(p_d), .flag_pin_wake(p_w));
    vis_core_model core (.ref_clk, .sys_rst, .slow, .irq_req, .irq_ack, .working_register(work),
        .status_word(stat), .indirect_pointer(ptr));
    task ck(input ok, input [127:0] m);
        begin
            checked = checked + 1;
            if (ok !== 1'b1) begin
                n_errors = n_errors + 1;
                $display("wrong value at %0t: %0s", $time, m);
            end
        end
    endtask
    task cyc(input integer n);
        repeat (n) @(posedge ref_clk);
    endtask
    task wr(input [5:0] a, input [7:0] d);
        begin
            @(posedge ref_clk) {reg_wr, reg_addr, reg_wdata} <= {1'b1, a, d};
            @(posedge ref_clk) reg_wr <= 1'b0;
        end
    endtask
    // read data stand only in the cycle after the strobe
    task rd(input [5:0] a, input [7:0] e);
        begin
            @(posedge ref_clk) {reg_rd, reg_addr} <= {1'b1, a};
            @(posedge ref_clk) reg_rd <= 1'b0;
            #1 ck(reg_rdata === e, "rd");
        end
    endtask
    task pulse(input [5:0] o, input [7:0] e);
        begin
            @(posedge ref_clk) {op, ev} <= {o, e};
            @(posedge ref_clk) {op, ev} <= 14'h0000;
        end
    endtask
    // bounded wait for the request line to reach a level
    task wt_req(input v);
        begin
            #1 k = 0;
            while (irq_req !== v && k < 60) begin
                @(posedge ref_clk);
                #1 k = k + 1;
            end
            ck(irq_req === v, "req");
        end
    endtask
    task t_flags;
        begin
            rd(6'h04, 8'h03);
            rd(6'h03, 8'hb0);
            rd(6'h0f, 8'h00);
            rd(6'h07, 8'h00);
            wr(6'h01, 8'h08);
            pulse(6'h00, 8'hff);
            rd(6'h0f, 8'h08);
            wr(6'h01, 8'hff);
            rd(6'h0f, 8'hf9);
            wr(6'h02, 8'h30);
            rd(6'h0e, 8'h30);
            rd(6'h0c, 8'h05);
            rd(6'h0d, 8'ha3);
            $display("flag test done");
        end
    endtask
    task t_prio;
        begin
            pulse(6'h01, 8'h00);
            for (i = 0; i < 8; i = i + 1) begin
                slow <= i[0];
                wt_req(1'b1);
                ck(irq_vector === VQ[79-10*i -: 10], "vec");
                wt_req(1'b0);
                ck(sh_s === ~sh_w && sh_p === (sh_w ^ 8'h5a) && sh_w !== last, "shadow");
                last = sh_w;
                wr(CA[47-6*i -: 6], CD[63-8*i -: 8]);
                pulse(6'h04, 8'h00);
            end
            cyc(4);
            ck(irq_req === 1'b0, "idle");
            rd(6'h04, 8'h0b);
            pulse(6'h02, 8'h00);
            rd(6'h04, 8'h03);
            $display("priority test done");
        end
    endtask
    // short pulse, long rising, falling select, then bypassed filter
    task t_ext;
        begin
            @(posedge ref_clk) ext_pin <= 1'b1;
            cyc(7); // one short of the filter
            ext_pin <= 1'b0;
            cyc(20);
            rd(6'h0f, 8'h00);
            @(posedge ref_clk) ext_pin <= 1'b1;
            cyc(20);
            rd(6'h0f, 8'h04);
            pulse(6'h01, 8'h00);
            wt_req(1'b1);
            ck(irq_vector === 10'h003, "ext vec");
            wt_req(1'b0);
            wr(6'h0f, 8'h00);
            wr(6'h03, 8'h30);
            @(posedge ref_clk) ext_pin <= 1'b0;
            cyc(20);
            rd(6'h0f, 8'h04);
            wr(6'h0f, 8'h00);
            wr(6'h03, 8'hb0);
            @(posedge ref_clk) {low_freq_crystal_mode, ext_pin} <= 2'b11;
            cyc(2);
            ext_pin <= 1'b0;
            cyc(10);
            rd(6'h0f, 8'h04);
            wr(6'h0f, 8'h00);
            $display("external pin test done");
        end
    endtask
    task t_sleep;
        begin
            wr(6'h01, 8'h02);
            @(posedge ref_clk) {reg_rd, reg_addr} <= {1'b1, 6'h05};
            @(posedge ref_clk) reg_rd <= 1'b0;
            pulse(6'h08, 8'h00);
            #1 ck(sleeping === 1'b1 && t_o === 1'b1 && p_d === 1'b0, "sleep");
            @(posedge ref_clk) port5 <= 8'h10;
            #1 k = 0;
            // wake stands one cycle
            while (wake !== 1'b1 && k < 12) begin
                @(posedge ref_clk);
                #1 k = k + 1;
            end
            ck(wake === 1'b1 && inl === 1'b1, "wake");
            cyc(2);
            #1 ck(p_w === 1'b1 && t_o === 1'b1 && p_d === 1'b0, "wake flags");
            rd(6'h0f, 8'h02);
            pulse(6'h01, 8'h00);
            wt_req(1'b1);
            ck(irq_vector === 10'h006, "port vec");
            wt_req(1'b0);
            $display("sleep test done");
        end
    endtask
    task t_wdt;
        begin
            @(posedge ref_clk) wdt_enable <= 1'b1;
            pd = !sleeping;
            pulse(6'h20, 8'h00);
            cyc(4);
            #1 ck(t_o === 1'b0 && p_w === 1'b0 && p_d === pd, "watchdog");
            rd(6'h0f, 8'h00);
            rd(6'h01, 8'h00);
            @(posedge ref_clk) rst_pin_n <= 1'b0;
            cyc(4);
            rst_pin_n <= 1'b1;
            #1 ck(rst_c === 1'b1, "reset held");
            cyc(8);
            #1 ck(rst_c === 1'b0 && t_o === 1'b0 && p_w === 1'b0 && p_d === 1'b1, "pin reset");
            pulse(6'h10, 8'h00);
            #1 ck(t_o === 1'b1 && p_d === 1'b1, "wdt clear");
            pulse(6'h08, 8'h00);
            pulse(6'h20, 8'h00);
            #1 ck(t_o === 1'b0 && p_d === 1'b0 && sleeping === 1'b0, "wdt in sleep");
            $display("reset test done");
        end
    endtask
    task end_sim;
        begin
            $display("checks %0d mismatches %0d", checked, n_errors);
            if (n_errors == 0 && checked > 0)
                $display("NO MISMATCHES");
            else
                $display("MISMATCHES SEEN");
            $finish;
        end
    endtask
    // hang guard, far beyond the few hundred cycles the tests need
    initial begin
        #80000 n_errors = n_errors + 1;
        $display("wrong value at %0t: watchdog expired", $time);
        end_sim;
    end
    initial begin
        cyc(10);
        sys_rst <= 1'b0;
        t_flags;
        t_prio;
        t_ext;
        t_sleep;
        t_wdt;
        end_sim;
    end
endmodule // tb_top

/* test/vis_core_model.sv */
`timescale 1ns/1ps
module vis_core_model (
    input wire ref_clk, // clock
    input wire sys_rst, // reset
    input wire slow, // late answers
    input wire irq_req, // vector request
    output reg irq_ack, // vector taken
    output wire [7:0] working_register, // live working reg
    output wire [7:0] status_word, // live status
    output wire [7:0] indirect_pointer // live pointer
);
    reg [7:0] tick_r; // stands in for changing core state
    reg [2:0] wait_r; // cycles the request has waited
    // context moves every cycle, so a capture one cycle late shows up
    assign working_register = tick_r;
    assign status_word = ~tick_r;
    assign indirect_pointer = tick_r ^ 8'h5a;
    // one ack per request, promptly or after five waits, never unasked
    always @(posedge ref_clk) begin
        tick_r <= sys_rst ? 8'h00 : tick_r + 8'h01;
        irq_ack <= 1'b0;
        if (sys_rst || !irq_req || irq_ack)
            wait_r <= 3'h0;
        else if (wait_r == (slow ? 3'h5 : 3'h0))
            irq_ack <= 1'b1;
        else
            wait_r <= wait_r + 3'h1;
    end
endmodule // vis_core_model

/* test/vis_irq_checker.sv */
`timescale 1ns/1ps
module vis_irq_checker (
    input wire ref_clk, // clock
    input wire sys_rst, // reset
    input wire wdt_timeout, // watchdog pulse
    input wire wdt_enable, // watchdog on
    input wire sleep_op, // sleep op
    input wire watchdog_clear_op, // watchdog clear op
    input wire irq_return_op, // return op
    input wire irq_ack, // vector taken
    input wire [7:0] working_register, // live working reg
    input wire [7:0] status_word, // live status
    input wire irq_req, // request
    input wire [9:0] irq_vector, // vector
    input wire wake, // wake
    input wire wake_resume_inline, // inline wake
    input wire [7:0] shadow_work, // saved working reg
    input wire [7:0] shadow_status, // saved status
    input wire restore_ctx, // restore pulse
    input wire sleeping, // asleep
    input wire flag_time_out, // time-out flag
    input wire flag_power_down, // power-down flag
    input wire flag_pin_wake // pin wake flag
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (sys_rst);
    // a request only ever names one of the ten fixed entry points
    a_vec_legal: assert property (irq_req |-> irq_vector inside {10'h003, 10'h006, 10'h009, 10'h00c,
        10'h00f, 10'h012, 10'h015, 10'h018, 10'h01b, 10'h01e}) else $error("illegal vector");
    a_req_awake: assert property (irq_req |-> !sleeping) else $error("request while asleep");
    a_ack_drop: assert property (irq_ack && irq_req |=> !irq_req) else $error("request held after ack");
    a_shadow_load: assert property (irq_ack && irq_req |=> shadow_work == $past(working_register)
        && shadow_status == $past(status_word)) else $error("shadow not loaded");
    a_ret_restore: assert property (irq_return_op |=> restore_ctx ##1 !restore_ctx) else $error("no restore");
    a_sleep_flags: assert property (sleep_op |=> sleeping && flag_time_out && !flag_power_down)
        else $error("sleep flags");
    a_wdc_flags: assert property (watchdog_clear_op && !wdt_timeout |=> flag_time_out && flag_power_down)
        else $error("watchdog clear flags");
    a_por_flags: assert property ($fell(sys_rst) |-> flag_time_out && flag_power_down && !flag_pin_wake)
        else $error("power-on flags");
    // watchdog reset is not synchronised and lands on the next edge; the span allows slack
    a_wdt_flags: assert property (wdt_timeout && wdt_enable && !sleeping |-> ##[1:4]
        (!flag_time_out && flag_power_down && !flag_pin_wake)) else $error("watchdog flags");
    a_inline_wake: assert property (wake_resume_inline |-> wake) else $error("inline without wake");
    a_wake_flags: assert property (wake && !(wdt_timeout && wdt_enable) |=> !sleeping && flag_pin_wake
        && flag_time_out && !flag_power_down) else $error("wake flags");
    c_ack: cover property (irq_ack && irq_req);
    c_inline: cover property (wake_resume_inline);
    c_restore: cover property ($rose(restore_ctx));
endmodule // vis_irq_checker
bind vis_irq_ctrl vis_irq_checker chk (.ref_clk, .sys_rst, .wdt_timeout, .wdt_enable, .sleep_op,
    .watchdog_clear_op, .irq_return_op, .irq_ack, .working_register, .status_word, .irq_req, .irq_vector,
    .wake, .wake_resume_inline, .shadow_work, .shadow_status, .restore_ctx, .sleeping, .flag_time_out,
    .flag_power_down, .flag_pin_wake);
